// [core/eprom_prog_defines.vh]
// Purpose: Constants for the EPROM programming controller
// Assumes: 250 MHz core clock, 4 ns period
// Notes: Times in ns; cycle counts derived from them
`ifndef EPROM_PROG_DEFINES_VH
`define EPROM_PROG_DEFINES_VH
`define CLK_PERIOD_NS 4
`define INIT_PULSE_NS 1000000
`define INIT_PULSE_CYC (`INIT_PULSE_NS / `CLK_PERIOD_NS)
`define DATA_VALID_NS 150
`define DATA_VALID_CYC ((`DATA_VALID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS 2000
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_PULSES 5'h19
`define OVER_FACTOR 3
// Timer load plus done latency in cycles
`define TIMER_LAG_CYC 2
`define ADDR_W 13
`define ADDR_NINE_BIT 9
`define ADDR_ZERO_BIT 0
`endif

// [core/pulse_timer.v]
// Purpose: Down-counting timer for strobe widths and setup delays
// Assumes: Load and count on one clock
// Notes: done_o pulses one cycle when count expires
`timescale 1ns/10ps
module pulse_timer (
  input wire core_clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [31:0] count_i,
  output reg busy_o,
  output reg done_o
);
  reg [31:0] cnt_r;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 32'h00000000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_r <= count_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_r <= 32'h00000001) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 32'h00000001;
        end
      end
    end
  end
endmodule // pulse_timer

// [core/eprom_programmer.v]
// Purpose: Drives EPROM pins for identify and intelligent programming
// Assumes: Data pins read back synchronous to core_clk_i
// Notes: id_hv_o requests the high voltage on address bit nine
`timescale 1ns/10ps
`include "eprom_prog_defines.vh"
module eprom_programmer #(
  parameter INIT_PULSE_CYCLES = `INIT_PULSE_CYC
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire id_start_i,
  input wire prog_start_i,
  input wire [12:0] prog_addr_i,
  input wire [7:0] prog_data_i,
  input wire [7:0] data_in_i,
  output reg [12:0] addr_o,
  output reg [7:0] data_out_o,
  output reg data_oe_o,
  output reg chip_sel_n_o,
  output reg out_en_n_o,
  output reg program_strobe_n_o,
  output reg id_hv_o,
  output reg busy_o,
  output reg done_o,
  output reg fail_o,
  output reg [7:0] maker_code_o,
  output reg [7:0] device_code_o,
  output reg [4:0] pulse_count_o
);
  localparam S_IDLE = 4'h0;
  localparam S_ID_SET = 4'h1;
  localparam S_ID_RD = 4'h2;
  localparam S_P_SET = 4'h3;
  localparam S_P_PULSE = 4'h4;
  localparam S_V_SET = 4'h5;
  localparam S_V_RD = 4'h6;
  localparam S_O_SET = 4'h7;
  localparam S_O_PULSE = 4'h8;
  localparam S_DONE = 4'h9;

  reg [3:0] state_r;
  reg id_hi_r;
  reg [4:0] iter_r;
  reg tload_r;
  reg [31:0] tcount_r;
  wire tbusy;
  wire tdone;

  pulse_timer timer_u (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .load_i(tload_r),
    .count_i(tcount_r),
    .busy_o(tbusy),
    .done_o(tdone)
  );

  function [31:0] over_cycles;
    input [4:0] x;
    begin
      over_cycles = `OVER_FACTOR * {27'h0000000, x} * INIT_PULSE_CYCLES - `TIMER_LAG_CYC;
    end
  endfunction

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      id_hi_r <= 1'b0;
      iter_r <= 5'h00;
      tload_r <= 1'b0;
      tcount_r <= 32'h00000000;
      addr_o <= 13'h0000;
      data_out_o <= 8'hFF;
      data_oe_o <= 1'b0;
      chip_sel_n_o <= 1'b1;
      out_en_n_o <= 1'b1;
      program_strobe_n_o <= 1'b1;
      id_hv_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      maker_code_o <= 8'h00;
      device_code_o <= 8'h00;
      pulse_count_o <= 5'h00;
    end else begin
      tload_r <= 1'b0;
      done_o <= 1'b0;
      case (state_r)
        S_IDLE: begin
          busy_o <= 1'b0;
          if (id_start_i) begin
            // Identify: bit nine high voltage, other lines low
            addr_o <= 13'h0000;
            id_hv_o <= 1'b1;
            chip_sel_n_o <= 1'b0;
            out_en_n_o <= 1'b0;
            program_strobe_n_o <= 1'b1;
            id_hi_r <= 1'b0;
            busy_o <= 1'b1;
            fail_o <= 1'b0;
            tload_r <= 1'b1;
            tcount_r <= `SETUP_CYC;
            state_r <= S_ID_SET;
          end else if (prog_start_i) begin
            addr_o <= prog_addr_i;
            // Erased bits are ones; only zeros get programmed
            data_out_o <= prog_data_i;
            data_oe_o <= 1'b1;
            chip_sel_n_o <= 1'b0;
            out_en_n_o <= 1'b1;
            iter_r <= 5'h00;
            busy_o <= 1'b1;
            fail_o <= 1'b0;
            tload_r <= 1'b1;
            tcount_r <= `SETUP_CYC;
            state_r <= S_P_SET;
          end
        end
        S_ID_SET: begin
          if (tdone) begin
            tload_r <= 1'b1;
            tcount_r <= `DATA_VALID_CYC;
            state_r <= S_ID_RD;
          end
        end
        S_ID_RD: begin
          if (tdone) begin
            if (!id_hi_r) begin
              // Bit zero low gives maker code
              maker_code_o <= data_in_i;
              addr_o[`ADDR_ZERO_BIT] <= 1'b1;
              id_hi_r <= 1'b1;
              tload_r <= 1'b1;
              tcount_r <= `SETUP_CYC;
              state_r <= S_ID_SET;
            end else begin
              device_code_o <= data_in_i;
              addr_o <= 13'h0000;
              id_hv_o <= 1'b0;
              chip_sel_n_o <= 1'b1;
              out_en_n_o <= 1'b1;
              state_r <= S_DONE;
            end
          end
        end
        S_P_SET: begin
          if (tdone) begin
            // Initial pulse, nominal width
            program_strobe_n_o <= 1'b0;
            iter_r <= iter_r + 5'h01;
            tload_r <= 1'b1;
            tcount_r <= INIT_PULSE_CYCLES - `TIMER_LAG_CYC;
            state_r <= S_P_PULSE;
          end
        end
        S_P_PULSE: begin
          if (tdone) begin
            program_strobe_n_o <= 1'b1;
            data_oe_o <= 1'b0;
            tload_r <= 1'b1;
            tcount_r <= `SETUP_CYC;
            state_r <= S_V_SET;
          end
        end
        S_V_SET: begin
          if (tdone) begin
            // Verify read: output enable low, strobe high
            out_en_n_o <= 1'b0;
            tload_r <= 1'b1;
            tcount_r <= `DATA_VALID_CYC;
            state_r <= S_V_RD;
          end
        end
        S_V_RD: begin
          if (tdone) begin
            // Sample only after data-valid delay
            out_en_n_o <= 1'b1;
            data_oe_o <= 1'b1;
            pulse_count_o <= iter_r;
            tload_r <= 1'b1;
            tcount_r <= `SETUP_CYC;
            if (data_in_i == data_out_o) begin
              state_r <= S_O_SET;
            end else if (iter_r >= `MAX_PULSES) begin
              fail_o <= 1'b1;
              data_oe_o <= 1'b0;
              chip_sel_n_o <= 1'b1;
              tload_r <= 1'b0;
              state_r <= S_DONE;
            end else begin
              state_r <= S_P_SET;
            end
          end
        end
        S_O_SET: begin
          if (tdone) begin
            // Overprogram width three times pulse count
            program_strobe_n_o <= 1'b0;
            tload_r <= 1'b1;
            tcount_r <= over_cycles(iter_r);
            state_r <= S_O_PULSE;
          end
        end
        S_O_PULSE: begin
          if (tdone) begin
            program_strobe_n_o <= 1'b1;
            data_oe_o <= 1'b0;
            chip_sel_n_o <= 1'b1;
            state_r <= S_DONE;
          end
        end
        S_DONE: begin
          done_o <= 1'b1;
          busy_o <= 1'b0;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // eprom_programmer

// [verif/eprom_programmer_checker.sv]
// Purpose: Pin timing checks for the programmer
// Assumes: Bound to eprom_programmer
// Notes: Widths counted in core clocks
`timescale 1ns/10ps
module eprom_programmer_checker #(
  parameter INIT_PULSE_CYCLES = 20
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [12:0] addr_o,
  input wire data_oe_o,
  input wire chip_sel_n_o,
  input wire out_en_n_o,
  input wire program_strobe_n_o,
  input wire id_hv_o,
  input wire fail_o,
  input wire [4:0] pulse_count_o
);
  reg [31:0] pw_r;
  reg [15:0] oe_r;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pw_r <= 32'h0;
      oe_r <= 16'h0;
    end else begin
      pw_r <= program_strobe_n_o ? 32'h0 : pw_r + 32'h1;
      oe_r <= out_en_n_o ? 16'h0 : oe_r + 16'h1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  pulse_width_a: assert property (
    $rose(program_strobe_n_o) |-> pw_r == INIT_PULSE_CYCLES
      || pw_r == 3 * pulse_count_o * INIT_PULSE_CYCLES) else $error("Strobe width wrong");
  verify_wait_a: assert property ($rose(out_en_n_o) |-> oe_r >= 16'h0026)
    else $error("Read too short");
  verify_pins_a: assert property (
    !out_en_n_o |-> program_strobe_n_o && !chip_sel_n_o && !data_oe_o) else $error("Bad read");
  strobe_pins_a: assert property (
    !program_strobe_n_o |-> data_oe_o && !chip_sel_n_o && out_en_n_o && !id_hv_o)
    else $error("Bad strobe");
  id_addr_a: assert property (id_hv_o |-> (addr_o & 13'h1DFE) == 13'h0000)
    else $error("Address not low");
  id_hold_a: assert property (
    $fell(out_en_n_o) && id_hv_o |-> (id_hv_o && !out_en_n_o) [*8]) else $error("Voltage lost");
  pulse_limit_a: assert property (pulse_count_o <= 5'h19)
    else $error("Too many pulses");
  fail_count_a: assert property (fail_o |-> pulse_count_o == 5'h19)
    else $error("Early failure");
  cover property ($rose(fail_o));
  cover property ($rose(id_hv_o));
  cover property ($rose(program_strobe_n_o) && pw_r > INIT_PULSE_CYCLES);
endmodule // eprom_programmer_checker
bind eprom_programmer eprom_programmer_checker #(.INIT_PULSE_CYCLES(INIT_PULSE_CYCLES)) u_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .addr_o(addr_o),
  .data_oe_o(data_oe_o),
  .chip_sel_n_o(chip_sel_n_o),
  .out_en_n_o(out_en_n_o),
  .program_strobe_n_o(program_strobe_n_o),
  .id_hv_o(id_hv_o),
  .fail_o(fail_o),
  .pulse_count_o(pulse_count_o)
);

// [verif/eprom_device_model.sv]
// Purpose: Behavioural EPROM in programming mode
// Assumes: need_i pulses program a byte
// Notes: Codes are arbitrary values
`timescale 1ns/10ps
module eprom_device_model #(
  parameter [7:0] MAKER = 8'hA5,
  parameter [7:0] DEVICE = 8'h5A
) (
  input wire [12:0] addr_i,
  input wire [7:0] data_i,
  input wire cs_n_i,
  input wire oe_n_i,
  input wire strobe_n_i,
  input wire hv_i,
  input wire [4:0] need_i,
  output reg [7:0] data_o
);
  reg [7:0] mem [0:8191];
  integer pulses;
  integer k;
  initial begin
    for (k = 0; k < 8192; k = k + 1) mem[k] = 8'hFF;
    pulses = 0;
    data_o = 8'h00;
  end
  always @(posedge cs_n_i) pulses = 0;
  always @(negedge strobe_n_i) begin
    if (!cs_n_i) begin
      pulses = pulses + 1;
      if (pulses >= need_i) mem[addr_i] = mem[addr_i] & data_i;
    end
  end
  always @(cs_n_i or oe_n_i or strobe_n_i or addr_i or hv_i) begin
    data_o = ~data_o;
    if (!cs_n_i && !oe_n_i && strobe_n_i)
      data_o <= #150 hv_i ? (addr_i[0] ? DEVICE : MAKER) : mem[addr_i];
  end
endmodule // eprom_device_model

// [verif/test_eprom_program_identify.sv]
// Purpose: Identify and program scenarios
// Assumes: Short initial pulse parameter
// Notes: Inputs change on falling edge
`timescale 1ns/10ps
module test_eprom_program_identify;
  reg core_clk_i = 0, rst_i = 1, id_start_i = 0, prog_start_i = 0;
  reg [12:0] prog_addr_i = 13'h0000;
  reg [7:0] prog_data_i = 8'h00;
  reg [4:0] need = 5'h01, exp_cnt;
  wire [7:0] dev_q, data_out_o, maker_code_o, device_code_o;
  wire [12:0] addr_o;
  wire [4:0] pulse_count_o;
  wire data_oe_o, chip_sel_n_o, out_en_n_o, program_strobe_n_o, id_hv_o, busy_o, done_o, fail_o;
  wire [7:0] data_in_i = data_oe_o ? data_out_o : dev_q;
  integer bad_count = 0, tests_run = 0, cyc = 0, i;
  reg [30:0] rows [0:2];
  eprom_programmer #(.INIT_PULSE_CYCLES(20)) u_eprom_programmer (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .id_start_i(id_start_i), .prog_start_i(prog_start_i),
    .prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i), .data_in_i(data_in_i),
    .addr_o(addr_o), .data_out_o(data_out_o), .data_oe_o(data_oe_o),
    .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o),
    .program_strobe_n_o(program_strobe_n_o), .id_hv_o(id_hv_o), .busy_o(busy_o),
    .done_o(done_o), .fail_o(fail_o), .maker_code_o(maker_code_o),
    .device_code_o(device_code_o), .pulse_count_o(pulse_count_o));
  eprom_device_model #(.MAKER(8'hA5), .DEVICE(8'h5A)) u_eprom_device_model (.addr_i(addr_o),
    .data_i(data_out_o), .cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o),
    .strobe_n_i(program_strobe_n_o), .hv_i(id_hv_o), .need_i(need), .data_o(dev_q));
  initial forever #2 core_clk_i = ~core_clk_i;
  task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s exp %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task run(input is_id);
    integer n;
    begin
      id_start_i = is_id;
      prog_start_i = !is_id;
      @(negedge core_clk_i);
      id_start_i = 0;
      prog_start_i = 0;
      check(busy_o, 32'h1, "busy");
      n = 0;
      while (done_o !== 1'b1 && n < 40000) begin
        @(negedge core_clk_i);
        n = n + 1;
      end
      check(done_o, 32'h1, "done");
      @(negedge core_clk_i);
      check(busy_o, 32'h0, "busy");
    end
  endtask
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      bad_count = bad_count + 1;
      $display("MISMATCH timeout exp done seen hang");
      conclude;
    end
  end
  initial begin
    rows[0] = {13'h0000, 8'h00, 5'h01, 5'h01};
    rows[1] = {13'h1FFF, 8'hA5, 5'h02, 5'h02};
    rows[2] = {13'h0155, 8'h3C, 5'h19, 5'h19};
    repeat (8) @(negedge core_clk_i);
    check(program_strobe_n_o, 32'h1, "strobe");
    check(busy_o, 32'h0, "busy");
    rst_i = 0;
    run(1);
    check(maker_code_o, 32'hA5, "maker");
    check(device_code_o, 32'h5A, "device");
    for (i = 0; i < 3; i = i + 1) begin
      {prog_addr_i, prog_data_i, need, exp_cnt} = rows[i];
      run(0);
      check(fail_o, 32'h0, "fail");
      check(pulse_count_o, exp_cnt, "count");
    end
    prog_addr_i = 13'h0AAA;
    need = 5'h1A;
    run(0);
    check(fail_o, 32'h1, "fail");
    check(pulse_count_o, 32'h19, "count");
    // Reset while the strobe is low, then identify again
    prog_addr_i = 13'h0F0F;
    need = 5'h02;
    prog_start_i = 1;
    @(negedge core_clk_i);
    prog_start_i = 0;
    while (program_strobe_n_o !== 1'b0) @(negedge core_clk_i);
    rst_i = 1;
    repeat (3) @(negedge core_clk_i);
    check(program_strobe_n_o, 32'h1, "strobe");
    check(chip_sel_n_o, 32'h1, "chipsel");
    check(data_oe_o, 32'h0, "data_oe");
    check(id_hv_o, 32'h0, "id_hv");
    check(busy_o, 32'h0, "busy");
    rst_i = 0;
    run(1);
    check(maker_code_o, 32'hA5, "maker");
    check(device_code_o, 32'h5A, "device");
    conclude;
  end
endmodule // test_eprom_program_identify
